// ---- rtl/dplf_failover.sv ----
`timescale 1ns/10ps

// Function
// - accept names 1..16 printable chars, reject others
// - each link reports master or responder type
// - never enable primary and secondary together
// - on configure primary active, secondary standby
// - primary fails, standby good: swap to secondary
// - secondary fails, primary recovered: revert to primary
// - responder mode drives one single port
// - no good standby: wait, resume whichever recovers
// - count active/standby transitions, readable total
module dplf_failover (
  input  wire logic                    clk_sys_in,    // 25 MHz clock
  input  wire logic                    reset_in,      // sync, active high
  input  wire logic                    config_in,     // configure: pair, or responder if responder_in
  input  wire logic                    responder_in,  // responder role
  input  wire dplf_pkg::dplf_pair_t    link_ok_in,    // async link good
  input  wire dplf_pkg::dplf_name_req_t name_req_in,  // name write
  output logic                         configured_out, // link is set up
  output dplf_pkg::dplf_type_t         link_type_out, // master/responder
  output dplf_pkg::dplf_pair_t         port_en_out,   // port active
  output logic                         resp_en_out,   // responder port on
  output logic [dplf_pkg::CNT_W-1:0]   changes_out,   // change total
  output logic                         name_ok_out,   // name accepted
  output logic                         name_err_out,  // name rejected
  output logic [4:0]                   name_len_out,  // stored length
  output logic [8*dplf_pkg::NAME_CHARS-1:0] name_out  // stored name
);

  // two-flop synchronisers for the link status pins
  dplf_pkg::dplf_pair_t ok_meta_reg;   // first stage, read by second only
  dplf_pkg::dplf_pair_t ok_sync_reg;   // safe link status

  // controller state
  dplf_pkg::dplf_state_t st_reg, st_next;
  dplf_pkg::dplf_pair_t  en_reg, en_next;
  logic                  resp_reg, resp_next;
  logic [dplf_pkg::CNT_W-1:0] cnt_reg, cnt_next;

  // registered status decodes, so the outputs come from flops
  logic                  cfg_reg, cfg_next;    // link configured
  dplf_pkg::dplf_type_t  type_reg, type_next;  // master or responder

  // name state
  logic                  nok_reg, nok_next;
  logic                  nerr_reg, nerr_next;
  logic [4:0]            nlen_reg, nlen_next;
  logic [8*dplf_pkg::NAME_CHARS-1:0] name_reg, name_next;

  // checks one name request: length range and printable chars
  function automatic logic name_valid(input dplf_pkg::dplf_name_req_t r);
    logic ok;
    logic [7:0] c;
    ok = (r.len >= dplf_pkg::NAME_LEN_MIN) &&
         (r.len <= dplf_pkg::NAME_LEN_MAX);
    for (int i = 0; i < dplf_pkg::NAME_CHARS; i++) begin
      c = r.chars[8*i +: 8];
      if ((5'(i) < r.len) &&
          ((c < dplf_pkg::CHAR_MIN) || (c > dplf_pkg::CHAR_MAX))) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // number of ports whose active state differs
  function automatic logic [1:0] flips(input logic [2:0] a,
                                       input logic [2:0] b);
    logic [2:0] d;
    d = a ^ b;
    return 2'({1'b0, d[0]} + {1'b0, d[1]} + {1'b0, d[2]});
  endfunction

  // synchroniser registers
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ok_meta_reg <= '0;
      ok_sync_reg <= '0;
    end else begin
      ok_meta_reg <= link_ok_in;
      ok_sync_reg <= ok_meta_reg;
    end
  end

  // failover next-state logic, evaluated every cycle
  always_comb begin
    st_next   = st_reg;
    en_next   = en_reg;
    resp_next = resp_reg;
    case (st_reg)
      dplf_pkg::DPLF_ST_UNCONF: begin
        en_next   = '0;
        resp_next = 1'b0;
      end
      dplf_pkg::DPLF_ST_PRI: begin
        // primary failed: swap only if standby good
        if (!ok_sync_reg.pri && ok_sync_reg.sec) begin
          st_next = dplf_pkg::DPLF_ST_SEC;
          en_next = '{pri: 1'b0, sec: 1'b1};
        end else if (!ok_sync_reg.pri) begin
          st_next = dplf_pkg::DPLF_ST_WAIT_PRI;
        end
      end
      dplf_pkg::DPLF_ST_SEC: begin
        // secondary failed: revert if primary recovered
        if (!ok_sync_reg.sec && ok_sync_reg.pri) begin
          st_next = dplf_pkg::DPLF_ST_PRI;
          en_next = '{pri: 1'b1, sec: 1'b0};
        end else if (!ok_sync_reg.sec) begin
          st_next = dplf_pkg::DPLF_ST_WAIT_SEC;
        end
      end
      dplf_pkg::DPLF_ST_WAIT_PRI: begin
        // primary down, waiting: own recovery wins ties
        if (ok_sync_reg.pri) begin
          st_next = dplf_pkg::DPLF_ST_PRI;
        end else if (ok_sync_reg.sec) begin
          st_next = dplf_pkg::DPLF_ST_SEC;
          en_next = '{pri: 1'b0, sec: 1'b1};
        end
      end
      dplf_pkg::DPLF_ST_WAIT_SEC: begin
        // secondary down, waiting
        if (ok_sync_reg.sec) begin
          st_next = dplf_pkg::DPLF_ST_SEC;
        end else if (ok_sync_reg.pri) begin
          st_next = dplf_pkg::DPLF_ST_PRI;
          en_next = '{pri: 1'b1, sec: 1'b0};
        end
      end
      dplf_pkg::DPLF_ST_RESP: begin
        // single port, active while its link is good
        en_next   = '0;
        resp_next = ok_sync_reg.pri;
      end
      default: begin
        st_next = dplf_pkg::DPLF_ST_UNCONF;
        en_next = '0;
      end
    endcase
    // configuration overrides: responder or fresh master pair
    if (!config_in) begin
      st_next   = dplf_pkg::DPLF_ST_UNCONF;
      en_next   = '0;
      resp_next = 1'b0;
    end else if (responder_in &&
                 st_reg != dplf_pkg::DPLF_ST_RESP) begin
      st_next   = dplf_pkg::DPLF_ST_RESP;
      en_next   = '0;
      resp_next = 1'b0;
    end else if (!responder_in &&
                 (st_reg == dplf_pkg::DPLF_ST_UNCONF ||
                  st_reg == dplf_pkg::DPLF_ST_RESP)) begin
      st_next   = dplf_pkg::DPLF_ST_PRI;
      en_next   = '{pri: 1'b1, sec: 1'b0};
      resp_next = 1'b0;
    end
  end

  // status decodes taken from the next state, one edge ahead
  always_comb begin
    cfg_next  = (st_next != dplf_pkg::DPLF_ST_UNCONF);
    type_next = (st_next == dplf_pkg::DPLF_ST_RESP) ?
                dplf_pkg::DPLF_TYPE_RESPONDER :
                dplf_pkg::DPLF_TYPE_MASTER;
  end

  // transition counter
  always_comb begin
    cnt_next = cnt_reg + dplf_pkg::CNT_W'(flips({en_reg, resp_reg},
                                                {en_next, resp_next}));
  end

  // name acceptance logic
  always_comb begin
    nok_next  = 1'b0;
    nerr_next = 1'b0;
    nlen_next = nlen_reg;
    name_next = name_reg;
    if (name_req_in.valid) begin
      if (name_valid(name_req_in)) begin
        nok_next  = 1'b1;
        nlen_next = name_req_in.len;
        name_next = name_req_in.chars;
      end else begin
        nerr_next = 1'b1;
      end
    end
  end

  // state registers; reset restores primary active
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st_reg   <= dplf_pkg::DPLF_ST_PRI;
      en_reg   <= '{pri: 1'b1, sec: 1'b0};
      resp_reg <= 1'b0;
      cfg_reg  <= 1'b1;
      type_reg <= dplf_pkg::DPLF_TYPE_MASTER;
      cnt_reg  <= dplf_pkg::CNT_RESET;
      nok_reg  <= 1'b0;
      nerr_reg <= 1'b0;
      nlen_reg <= '0;
      name_reg <= '0;
    end else begin
      st_reg   <= st_next;
      en_reg   <= en_next;
      resp_reg <= resp_next;
      cfg_reg  <= cfg_next;
      type_reg <= type_next;
      cnt_reg  <= cnt_next;
      nok_reg  <= nok_next;
      nerr_reg <= nerr_next;
      nlen_reg <= nlen_next;
      name_reg <= name_next;
    end
  end

  // outputs straight from flip-flops
  assign configured_out = cfg_reg;
  assign link_type_out  = type_reg;
  assign port_en_out    = en_reg;
  assign resp_en_out    = resp_reg;
  assign changes_out    = cnt_reg;
  assign name_ok_out    = nok_reg;
  assign name_err_out   = nerr_reg;
  assign name_len_out   = nlen_reg;
  assign name_out       = name_reg;

endmodule

// ---- rtl/dplf_pkg.sv ----
package dplf_pkg;

  // link name limits, in characters
  localparam logic [4:0] NAME_LEN_MIN = 5'h01;
  localparam logic [4:0] NAME_LEN_MAX = 5'h10;
  localparam int         NAME_CHARS   = 16;

  // printable character range (space through tilde)
  localparam logic [7:0] CHAR_MIN = 8'h20;
  localparam logic [7:0] CHAR_MAX = 8'h7e;

  // state change counter width and reset value
  localparam int          CNT_W     = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // link type indication
  typedef enum logic [0:0] {
    DPLF_TYPE_MASTER    = 1'b0,
    DPLF_TYPE_RESPONDER = 1'b1
  } dplf_type_t;

  // failover controller states
  typedef enum logic [2:0] {
    DPLF_ST_UNCONF    = 3'b000,
    DPLF_ST_PRI       = 3'b001,
    DPLF_ST_SEC       = 3'b010,
    DPLF_ST_WAIT_PRI  = 3'b011,
    DPLF_ST_WAIT_SEC  = 3'b100,
    DPLF_ST_RESP      = 3'b101
  } dplf_state_t;

  // per-port link health and enable pair
  typedef struct packed {
    logic pri;
    logic sec;
  } dplf_pair_t;

  // name write request
  typedef struct packed {
    logic       valid;
    logic [4:0] len;
    logic [8*NAME_CHARS-1:0] chars;
  } dplf_name_req_t;

endpackage

// ---- bench/dplf_resp_mdl.sv ----
`timescale 1ns/10ps
// far end: two responder ports reporting link health
module dplf_resp_mdl (
  input  wire logic            clk_sys_in,  // sampling clock
  input  wire logic            up_pri_in,   // primary far link up
  input  wire logic            up_sec_in,   // secondary far link up
  output dplf_pkg::dplf_pair_t link_ok_out  // link good per port
);
  dplf_pkg::dplf_pair_t ok_reg, ok_next;    // reported health
  // both responders share one segment, one status pair
  always_comb begin
    ok_next = '{pri: up_pri_in, sec: up_sec_in}; // failure sent back
  end
  // register the report like a real link pulse detector
  always_ff @(posedge clk_sys_in) begin
    ok_reg <= ok_next;
  end
  assign link_ok_out = ok_reg;
endmodule

// ---- bench/dplf_failover_chk.sv ----
`timescale 1ns/10ps
module dplf_chk (
  input wire logic                      clk_sys_in,
  input wire logic                      reset_in,
  input wire logic                      config_in,
  input wire logic                      responder_in,
  input wire dplf_pkg::dplf_pair_t      link_ok_in,
  input wire dplf_pkg::dplf_name_req_t  name_req_in,
  input wire logic                      configured_out,
  input wire dplf_pkg::dplf_type_t      link_type_out,
  input wire dplf_pkg::dplf_pair_t      port_en_out,
  input wire logic                      resp_en_out,
  input wire logic [dplf_pkg::CNT_W-1:0] changes_out,
  input wire logic                      name_ok_out,
  input wire logic                      name_err_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  wire mst = config_in && !responder_in; // master pair selected
  wire rsp = configured_out && link_type_out; // responder role
  a_never_both: assert property (
    !(port_en_out.pri && port_en_out.sec)) else $error("both enabled");
  a_name_short: assert property (
    name_req_in.valid && name_req_in.len == 5'h00 |=> name_err_out)
    else $error("empty name kept");
  a_name_long: assert property (
    name_req_in.valid && name_req_in.len > 5'h10 |=> name_err_out)
    else $error("long name kept");
  a_fail_swap: assert property (
    (mst && port_en_out.pri && link_ok_in == 2'b01) [*3] |=> port_en_out.sec)
    else $error("no failover");
  a_fail_revert: assert property (
    (mst && port_en_out.sec && link_ok_in == 2'b10) [*3] |=> port_en_out.pri)
    else $error("no revert");
  a_wait_hold: assert property (
    (mst && port_en_out.pri && link_ok_in == 2'b00) [*3] |=> port_en_out.pri)
    else $error("left port while waiting");
  a_count_swap: assert property (
    $rose(port_en_out.sec) && $fell(port_en_out.pri)
    |-> changes_out == $past(changes_out) + 16'h0002)
    else $error("swap not counted");
  a_resp_single: assert property (
    rsp |-> port_en_out == 2'b00) else $error("pair on in responder");
  a_resp_follow: assert property (
    (rsp && config_in && responder_in && link_ok_in.pri) [*3]
    |=> resp_en_out)
    else $error("responder port off");
  cover property (port_en_out.sec);
  cover property (name_ok_out);
  cover property (resp_en_out);
endmodule
bind dplf_failover dplf_chk chk (.clk_sys_in(clk_sys_in),
  .reset_in(reset_in), .config_in(config_in),
  .responder_in(responder_in), .link_ok_in(link_ok_in),
  .name_req_in(name_req_in), .configured_out(configured_out),
  .link_type_out(link_type_out), .port_en_out(port_en_out),
  .resp_en_out(resp_en_out), .changes_out(changes_out),
  .name_ok_out(name_ok_out), .name_err_out(name_err_out));

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic clk_sys_in, reset_in, config_in, responder_in; // design controls
  logic up_pri, up_sec;                   // far link commands
  logic configured, resp_en, name_ok, name_err;
  logic [4:0] name_len;                   // stored name length
  logic [8*dplf_pkg::NAME_CHARS-1:0] name; // stored name
  logic [dplf_pkg::CNT_W-1:0] changes;    // state change total
  dplf_pkg::dplf_pair_t link_ok, port_en;
  dplf_pkg::dplf_type_t link_type;
  dplf_pkg::dplf_name_req_t name_req;
  int num_errors, compares;
  dplf_resp_mdl far (.clk_sys_in(clk_sys_in), .up_pri_in(up_pri),
    .up_sec_in(up_sec), .link_ok_out(link_ok));
  dplf_failover uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .config_in(config_in), .responder_in(responder_in),
    .link_ok_in(link_ok), .name_req_in(name_req),
    .configured_out(configured), .link_type_out(link_type),
    .port_en_out(port_en), .resp_en_out(resp_en), .changes_out(changes),
    .name_ok_out(name_ok), .name_err_out(name_err),
    .name_len_out(name_len), .name_out(name));
  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tick(int n); // settle after n edges
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wait_en(logic [1:0] exp); // bounded wait on enables
    for (int i = 0; i < 10 && port_en !== exp; i++) tick(1);
    chk("port_en", 16'(exp), 16'(port_en));
    if (port_en !== exp) give_verdict();
  endtask
  task automatic t_links(); // failover, revert, wait
    @(posedge clk_sys_in) up_pri <= 1'b0;
    wait_en(2'b01);
    chk("changes", 16'h0002, changes);
    @(posedge clk_sys_in) {up_pri, up_sec} <= 2'b10;
    wait_en(2'b10);
    @(posedge clk_sys_in) up_pri <= 1'b0;
    tick(8);
    chk("hold", 16'h0002, 16'(port_en));
    @(posedge clk_sys_in) up_sec <= 1'b1;
    wait_en(2'b01);
    chk("changes", 16'h0006, changes);
    @(posedge clk_sys_in) up_sec <= 1'b0;
    tick(8);
    chk("hold_sec", 16'h0001, 16'(port_en));
    @(posedge clk_sys_in) up_pri <= 1'b1;
    wait_en(2'b10);
    chk("changes", 16'h0008, changes);
  endtask
  task automatic t_name(); // lengths 0,1,16,17 and a bad char
    logic [4:0] lens [5] = '{5'h00, 5'h01, 5'h10, 5'h11, 5'h02};
    logic [4:0] keep [5] = '{5'h00, 5'h01, 5'h10, 5'h10, 5'h10};
    logic [127:0] c;
    for (int i = 0; i < 5; i++) begin
      c = {16{8'h41}};
      if (i == 1) c[7:0] = 8'h20;        // space is legal
      if (i == 4) c[15:8] = 8'h1f;       // control char
      @(posedge clk_sys_in) name_req <= '{1'b1, lens[i], c};
      @(posedge clk_sys_in) name_req.valid <= 1'b0;
      #1;
      chk("name_ok", 16'(i inside {1, 2}), 16'(name_ok));
      chk("name_len", 16'(keep[i]), 16'(name_len));
      chk("name_err", 16'(i inside {0, 3, 4}), 16'(name_err));
    end
    chk("name_lo", 16'h4141, name[15:0]);
  endtask
  task automatic t_resp(); // responder role and unconfigure
    @(posedge clk_sys_in) {responder_in, up_pri} <= 2'b11;
    tick(6);
    chk("type", 16'h0001, 16'(link_type));
    chk("pair_off", 16'h0000, 16'(port_en));
    chk("resp_on", 16'h0001, 16'(resp_en));
    @(posedge clk_sys_in) config_in <= 1'b0;
    tick(3);
    chk("config", 16'h0000, 16'(configured));
    @(posedge clk_sys_in) {reset_in, config_in, responder_in} <= 3'b110;
    tick(2);
    @(posedge clk_sys_in) reset_in <= 1'b0;
    tick(1);
    chk("rst_en", 16'h0002, 16'(port_en));
    chk("rst_cnt", 16'h0000, changes);
    chk("rst_cfg", 16'h0001, 16'(configured));
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    {reset_in, config_in, responder_in, up_pri, up_sec} = 5'b11011;
    name_req = '0;
    repeat (16) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    tick(2);
    chk("init_en", 16'h0002, 16'(port_en));
    chk("init_cnt", 16'h0000, changes);
    chk("type", 16'h0000, 16'(link_type));
    t_links();
    t_name();
    t_resp();
    give_verdict();
  end
endmodule
